// File: rtl/trig_ctrl.sv
`timescale 1ns/10ps
module trig_ctrl
  import trig_ctrl_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES,  // cycles per ms, shorten in sim
  parameter int DISP_MS  = DISP_TEST_MS,  // total, above ALL_SEG_MS
  parameter int MEM_MS   = MEM_TEST_MS
)(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Trigger inputs, one-cycle pulses or levels
  input  wire logic        ext_trig_b,      // falling edge is a trigger
  input  wire logic        src_operate,     // level: source in operate
  input  wire logic        bus_exec,        // pulse: bus execute
  input  wire logic        bus_get,         // pulse: group execute
  input  wire logic        bus_talk,        // pulse: talk addressed
  input  wire logic        key_trigger,     // pulse: front trigger key
  input  wire logic        key_any,         // pulse: any front key
  input  wire logic        remote,          // level: remote control
  // Measurement handshake
  output logic             conv_start,      // pulse: take a reading
  input  wire logic        conv_done,       // pulse: reading finished
  output logic             store_write,     // pulse: write to data store
  output logic             buffer_clear,    // pulse: empty reading buffer
  // Self-test and memory checks
  output logic [DIGITS-1:0] digit_all_on,   // level: digits lit
  input  wire logic        rom_ok,
  input  wire logic        ram_ok,
  // Debug multiplexer
  output logic             mux_lock,
  output logic [1:0]       mux_sel,
  // Status
  output logic             trigger_overrun_error,
  output logic             menu_advance     // pulse: next menu item
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum {S_BOOT, S_IDLE, S_DELAY, S_CONV, S_WAIT} seq_t;
  typedef enum {T_OFF, T_ALL, T_DIGIT, T_MEM, T_FAIL} test_t;

  typedef struct packed {
    logic [31:0]         tick_cnt;
    logic                tick;
    logic                oneshot;
    logic                store_on;
    logic [19:0]         interval;
    logic [19:0]         delay;
    trigger_source_select_t           source;
    logic                sv_oneshot;   // power-up store
    logic [19:0]         sv_interval;
    logic [19:0]         sv_delay;
    trigger_source_select_t           sv_source;
    seq_t                seq;
    logic [19:0]         ms_cnt;
    logic                overrun;
    logic                conv_start;
    logic                store_write;
    logic                buf_clear;
    logic                menu_adv;
    test_t               test;
    logic [31:0]         test_ms;
    logic [3:0]          digit;
    logic                rom_err;
    logic                ram_err;
    logic                dbg_en;
    logic [1:0]          dbg_sel;
    logic                ext_q;
    logic                op_q;
    logic [31:0]         rdata;
  } state_t;

  state_t cur_r;
  state_t nxt;
  logic        trig_evt;
  logic [19:0] eff_interval;
  // Trigger source merge; the front key works with any source unless remote is set
  always_comb
  begin
    unique case (cur_r.source)
      SRC_EXTERNAL: trig_evt = cur_r.ext_q & ~ext_trig_b;
      SRC_OPERATE:  trig_evt = src_operate & ~cur_r.op_q;
      SRC_BUS_X:    trig_evt = bus_exec;
      SRC_GET:      trig_evt = bus_get;
      SRC_TALK:     trig_evt = bus_talk;
      default:      trig_evt = 1'b0;
    endcase
    if (key_trigger && !remote)
      trig_evt = 1'b1;
    // Short intervals only while storing, else 50 ms floor
    if (!cur_r.store_on && cur_r.interval < INTERVAL_FLOOR_MS)
      eff_interval = INTERVAL_FLOOR_MS;
    else
      eff_interval = cur_r.interval;
  end

  // Next state of the whole block
  always_comb
  begin
    logic [19:0] wv;
    logic        tst_start;
    wv        = reg_wdata[19:0];
    tst_start = 1'b0;
    nxt       = cur_r;
    nxt.conv_start  = 1'b0;
    nxt.store_write = 1'b0;
    nxt.buf_clear   = 1'b0;
    nxt.menu_adv    = 1'b0;
    nxt.ext_q       = ext_trig_b;
    nxt.op_q        = src_operate;

    // Common millisecond timebase for delay and interval
    nxt.tick     = cur_r.tick_cnt >= 32'(TICK_DIV - 1);
    nxt.tick_cnt = nxt.tick ? '0 : cur_r.tick_cnt + 32'h1;

    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_MODE:
        begin
          nxt.oneshot  = reg_wdata[MODE_ONESHOT_BIT];
          nxt.store_on = reg_wdata[MODE_STORE_BIT];
        end
        ADDR_INTERVAL:
          if (!cur_r.oneshot && wv >= INTERVAL_MIN_MS
              && wv <= INTERVAL_MAX_MS)
            nxt.interval = wv;
        ADDR_DELAY:
          if (wv <= DELAY_MAX_MS)
            nxt.delay = wv;
        ADDR_SOURCE:
          if (reg_wdata[2:0] <= 3'h4)
            nxt.source = trigger_source_select_t'(reg_wdata[2:0]);
        ADDR_DEFAULTS:
        begin
          unique case (def_action_t'(reg_wdata[1:0]))
            DEF_OK: nxt.menu_adv = 1'b1;
            DEF_SAVE:
            begin
              nxt.sv_oneshot  = cur_r.oneshot;
              nxt.sv_interval = cur_r.interval;
              nxt.sv_delay    = cur_r.delay;
              nxt.sv_source   = cur_r.source;
              nxt.menu_adv    = 1'b1;
            end
            DEF_RECALL:
            begin
              nxt.oneshot   = cur_r.sv_oneshot;
              nxt.interval  = cur_r.sv_interval;
              nxt.delay     = cur_r.sv_delay;
              nxt.source    = cur_r.sv_source;
              nxt.buf_clear = 1'b1;
              nxt.seq       = S_IDLE;
            end
            DEF_FACTORY:
            begin
              nxt.oneshot     = FACT_ONESHOT;
              nxt.interval    = FACT_INTERVAL_MS;
              nxt.delay       = FACT_DELAY_MS;
              nxt.source      = FACT_SOURCE;
              nxt.sv_oneshot  = FACT_ONESHOT;
              nxt.sv_interval = FACT_INTERVAL_MS;
              nxt.sv_delay    = FACT_DELAY_MS;
              nxt.sv_source   = FACT_SOURCE;
              nxt.buf_clear   = 1'b1;
              nxt.seq         = S_IDLE;
            end
          endcase
        end
        ADDR_SELFTEST: tst_start = reg_wdata[0];
        ADDR_DEBUG:
        begin
          nxt.dbg_en  = reg_wdata[0];
          if (reg_wdata[2:1] <= 2'h2)
            nxt.dbg_sel = reg_wdata[2:1];
        end
        ADDR_ERRCLR: nxt.overrun = cur_r.overrun & ~reg_wdata[0];
        default: ;
      endcase
    end

    // Trigger sequencer; settings change aborts a running series
    unique case (cur_r.seq)
      S_BOOT:
      begin
        // Load power-up store before any trigger is accepted
        nxt.oneshot  = cur_r.sv_oneshot;
        nxt.interval = cur_r.sv_interval;
        nxt.delay    = cur_r.sv_delay;
        nxt.source   = cur_r.sv_source;
        nxt.seq      = S_IDLE;
      end
      S_IDLE:
        if (trig_evt)
        begin
          nxt.ms_cnt = '0;
          nxt.seq    = S_DELAY;
        end
      S_DELAY:
      begin
        if (trig_evt)
          nxt.overrun = 1'b1;
        if (cur_r.ms_cnt >= cur_r.delay)
        begin
          nxt.conv_start  = 1'b1;
          nxt.store_write = cur_r.store_on;
          nxt.ms_cnt      = '0;
          nxt.seq         = S_CONV;
        end
        else if (cur_r.tick)
          nxt.ms_cnt = cur_r.ms_cnt + 20'h1;
      end
      S_CONV:
      begin
        if (trig_evt)
          nxt.overrun = 1'b1;
        if (cur_r.tick)
          nxt.ms_cnt = cur_r.ms_cnt + 20'h1;
        if (conv_done)
          nxt.seq = cur_r.oneshot ? S_IDLE : S_WAIT;
      end
      S_WAIT:
      begin
        // Multiple mode paces readings from the previous start
        if (trig_evt)
          nxt.overrun = 1'b1;
        if (cur_r.oneshot)
          nxt.seq = S_IDLE;
        else if (cur_r.ms_cnt + 20'h1 >= eff_interval && cur_r.tick)
        begin
          nxt.conv_start  = 1'b1;
          nxt.store_write = cur_r.store_on;
          nxt.ms_cnt      = '0;
          nxt.seq         = S_CONV;
        end
        else if (cur_r.tick)
          nxt.ms_cnt = cur_r.ms_cnt + 20'h1;
      end
    endcase
    // Abort a series when the trigger setup is rewritten
    if (reg_wr && reg_addr <= ADDR_SOURCE && cur_r.seq != S_BOOT)
      nxt.seq = S_IDLE;

    // Self-test sequence
    unique case (cur_r.test)
      T_OFF:
        if (tst_start)
        begin
          nxt.test    = T_ALL;
          nxt.test_ms = '0;
          nxt.rom_err = 1'b0;
          nxt.ram_err = 1'b0;
        end
      T_ALL, T_DIGIT:
      begin
        if (cur_r.tick)
          nxt.test_ms = cur_r.test_ms + 32'h1;
        if (cur_r.test == T_ALL && cur_r.test_ms >= 32'(ALL_SEG_MS))
        begin
          nxt.test  = T_DIGIT;
          nxt.digit = '0;
        end
        else if (cur_r.test == T_DIGIT)
        begin
          if (cur_r.test_ms >= 32'(DISP_MS))
          begin
            nxt.test    = T_MEM;
            nxt.test_ms = '0;
          end
          else
            nxt.digit = 4'((cur_r.test_ms - 32'(ALL_SEG_MS)) * DIGITS
                           / 32'(DISP_MS - ALL_SEG_MS));
        end
      end
      T_MEM:
      begin
        if (cur_r.tick)
          nxt.test_ms = cur_r.test_ms + 32'h1;
        if (cur_r.test_ms >= 32'(MEM_MS))
        begin
          nxt.rom_err = ~rom_ok;
          nxt.ram_err = ~ram_ok;
          if (rom_ok && ram_ok)
          begin
            nxt.test     = T_OFF;
            nxt.menu_adv = 1'b1;
          end
          else
            nxt.test = T_FAIL;
        end
      end
      T_FAIL:
        if (key_any)
        begin
          nxt.test    = T_OFF;
          nxt.rom_err = 1'b0;
          nxt.ram_err = 1'b0;
        end
    endcase

    // Read data, valid in the cycle after the strobe
    nxt.rdata = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_MODE:     nxt.rdata = {30'h0, cur_r.store_on, cur_r.oneshot};
        ADDR_INTERVAL: nxt.rdata = {12'h0, cur_r.interval};
        ADDR_DELAY:    nxt.rdata = {12'h0, cur_r.delay};
        ADDR_SOURCE:   nxt.rdata = {29'h0, cur_r.source};
        ADDR_DEBUG:    nxt.rdata = {29'h0, cur_r.dbg_sel, cur_r.dbg_en};
        ADDR_STATUS:
        begin
          nxt.rdata[ST_OVERRUN_BIT]  = cur_r.overrun;
          nxt.rdata[ST_BUSY_BIT]     = (cur_r.seq != S_IDLE);
          nxt.rdata[ST_ROMERR_BIT]   = cur_r.rom_err;
          nxt.rdata[ST_RAMERR_BIT]   = cur_r.ram_err;
          nxt.rdata[ST_TESTRUN_BIT]  = (cur_r.test != T_OFF);
          nxt.rdata[ST_MENUADV_BIT]  = cur_r.menu_adv;
          nxt.rdata[ST_BUFEMPTY_BIT] = cur_r.buf_clear;
        end
        default:       nxt.rdata = '0;
      endcase
    end
  end

  // Register the whole state; reset lands in boot to load the store
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      cur_r             <= '0;
      cur_r.seq         <= S_BOOT;
      cur_r.sv_oneshot  <= FACT_ONESHOT;
      cur_r.sv_interval <= FACT_INTERVAL_MS;
      cur_r.sv_delay    <= FACT_DELAY_MS;
      cur_r.sv_source   <= FACT_SOURCE;
      cur_r.ext_q       <= 1'b1;
    end
    else
      cur_r <= nxt;
  end

  // Outputs straight from the state
  assign reg_rdata             = cur_r.rdata;
  assign conv_start            = cur_r.conv_start;
  assign store_write           = cur_r.store_write;
  assign buffer_clear          = cur_r.buf_clear;
  assign trigger_overrun_error = cur_r.overrun;
  assign menu_advance          = cur_r.menu_adv;
  assign mux_lock              = cur_r.dbg_en;
  assign mux_sel               = cur_r.dbg_sel;

  // All digits lit first, then one at a time
  always_comb
  begin
    digit_all_on = '0;
    if (cur_r.test == T_ALL)
      digit_all_on = '1;
    else if (cur_r.test == T_DIGIT)
      digit_all_on[cur_r.digit[2:0]] = 1'b1;
  end

endmodule : trig_ctrl

// File: shared/trig_ctrl_pkg.sv
package trig_ctrl_pkg;

  // ==========================================================================
  // Register map (word addresses on the plain register port)
  // ==========================================================================
  localparam logic [3:0] ADDR_MODE     = 4'h0;  // bit0 one-shot, bit1 store
  localparam logic [3:0] ADDR_INTERVAL = 4'h1;  // trigger_interval_setting ms
  localparam logic [3:0] ADDR_DELAY    = 4'h2;  // trigger_delay_setting ms
  localparam logic [3:0] ADDR_SOURCE   = 4'h3;  // trigger_source_select
  localparam logic [3:0] ADDR_DEFAULTS = 4'h4;  // write: defaults action
  localparam logic [3:0] ADDR_SELFTEST = 4'h5;  // write bit0: start test
  localparam logic [3:0] ADDR_DEBUG    = 4'h6;  // bit0 enable, bits2:1 mux
  localparam logic [3:0] ADDR_STATUS   = 4'h7;  // read: block state
  localparam logic [3:0] ADDR_ERRCLR   = 4'h8;  // write 1 clears overrun flag

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int MODE_ONESHOT_BIT = 0;
  localparam int MODE_STORE_BIT   = 1;
  localparam int ST_OVERRUN_BIT   = 0;
  localparam int ST_BUSY_BIT      = 1;
  localparam int ST_ROMERR_BIT    = 2;
  localparam int ST_RAMERR_BIT    = 3;
  localparam int ST_TESTRUN_BIT   = 4;
  localparam int ST_MENUADV_BIT   = 5;
  localparam int ST_BUFEMPTY_BIT  = 6;

  // ==========================================================================
  // Enumerations
  // ==========================================================================
  typedef enum logic [2:0] {
    SRC_EXTERNAL = 3'h0,
    SRC_OPERATE  = 3'h1,
    SRC_BUS_X    = 3'h2,
    SRC_GET      = 3'h3,
    SRC_TALK     = 3'h4
  } trigger_source_select_t;

  typedef enum logic [1:0] {
    DEF_OK      = 2'h0,
    DEF_SAVE    = 2'h1,
    DEF_RECALL  = 2'h2,
    DEF_FACTORY = 2'h3
  } def_action_t;

  // ==========================================================================
  // Values and timing
  // ==========================================================================
  localparam int         MS_WIDTH          = 20;  // up to 999999 ms
  localparam logic [19:0] INTERVAL_MIN_MS  = 20'h0000a;  // 10 ms
  localparam logic [19:0] INTERVAL_MAX_MS  = 20'hf423f;  // 999999 ms
  localparam logic [19:0] INTERVAL_FLOOR_MS = 20'h00032; // 50 ms unstored
  localparam logic [19:0] DELAY_MAX_MS     = 20'hf423f;
  localparam logic [19:0] FACT_INTERVAL_MS = 20'h000af;  // 175 ms
  localparam logic [19:0] FACT_DELAY_MS    = 20'h00000;
  localparam logic        FACT_ONESHOT     = 1'b0;       // multiple
  localparam trigger_source_select_t   FACT_SOURCE      = SRC_EXTERNAL;
  localparam int          CLK_HZ           = 200000000;
  localparam int          TICK_US          = 1000;       // 1 ms tick
  localparam int          TICK_CYCLES      = CLK_HZ / 1000000 * TICK_US;
  localparam int          DISP_TEST_S      = 17;
  localparam int          MEM_TEST_S       = 5;
  localparam int          DISP_TEST_MS     = DISP_TEST_S * 1000;
  localparam int          MEM_TEST_MS      = MEM_TEST_S * 1000;
  localparam int          DIGITS           = 8;
  localparam int          ALL_SEG_MS       = 1000;  // all-segments phase

endpackage : trig_ctrl_pkg

// File: sim/trig_ctrl_partner.sv
`timescale 1ns/10ps
// ============================================================
// Far side: external trigger source and converter
module trig_ctrl_partner (
  // Clock
  input  wire logic mclk,
  // Requests from the bench
  input  wire logic fire,
  input  wire logic slow,
  // Converter handshake and trigger line
  input  wire logic conv_start,
  output logic      conv_done,
  output logic      ext_trig_b
);
  logic [3:0] low_r  = 4'h0;
  logic [3:0] busy_r = 4'h0;
  // Low pulse of three cycles; the pull-up holds the line high when idle
  always_ff @(posedge mclk)
  begin
    low_r <= fire ? 4'h3 : low_r - 4'(low_r != 4'h0);
    if (conv_start)
      busy_r <= slow ? 4'hc : 4'h2;
    else
      busy_r <= busy_r - 4'(busy_r != 4'h0);
  end
  assign conv_done  = busy_r == 4'h1;
  assign ext_trig_b = low_r == 4'h0;  // Falling edge starts a trigger
endmodule : trig_ctrl_partner

// File: sim/trig_ctrl_checker.sv
`timescale 1ns/10ps
// ============================================================
// Port checks on the trigger controller
module trig_ctrl_checker
  import trig_ctrl_pkg::*;
(
  // Clock, reset and register port
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // Outputs under watch
  input wire logic        conv_start,
  input wire logic        store_write,
  input wire logic        buffer_clear,
  input wire logic        mux_lock,
  input wire logic [1:0]  mux_sel,
  input wire logic        trigger_overrun_error,
  input wire logic        menu_advance
);
  logic [1:0] sel_w;
  assign sel_w = reg_wdata[2:1];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Defaults command and debug steps
  sequence s_def_wr;
    reg_wr && reg_addr == ADDR_DEFAULTS;
  endsequence
  sequence s_reload;
    s_def_wr ##0 reg_wdata[1];
  endsequence
  sequence s_dbg_ok;
    reg_wr && reg_addr == ADDR_DEBUG && reg_wdata[0] && sel_w != 2'h3;
  endsequence
  AST_CONV_PULSE: assert property (
    conv_start |=> !conv_start [*8]) else $error("conv_start too long");
  AST_STORE_PACE: assert property (
    store_write |-> conv_start) else $error("store write off pace");
  AST_BUF_CLEAR: assert property (
    s_reload |=> buffer_clear) else $error("buffer not cleared");
  AST_MENU_ADV: assert property (
    s_def_wr ##0 !reg_wdata[1] |=> menu_advance) else $error("no advance");
  AST_MENU_EXIT: assert property (
    s_reload |=> !menu_advance) else $error("advance after reload");
  AST_OVR_HOLD: assert property (
    trigger_overrun_error && !reg_wr |=> trigger_overrun_error)
    else $error("overrun dropped");
  AST_MUX_LEGAL: assert property (
    mux_lock |-> mux_sel != 2'h3) else $error("illegal mux state");
  AST_MUX_LOCK: assert property (
    s_dbg_ok |=> mux_lock && mux_sel == $past(sel_w))
    else $error("mux not locked");
endmodule : trig_ctrl_checker

bind trig_ctrl trig_ctrl_checker i_trig_ctrl_checker (.mclk, .rst_b,
  .reg_addr, .reg_wdata, .reg_wr, .conv_start, .store_write, .buffer_clear,
  .mux_lock, .mux_sel, .trigger_overrun_error, .menu_advance);

// File: sim/trig_ctrl_bench.sv
`timescale 1ns/10ps
// ============================================================
// Trigger controller bench
module trig_ctrl_bench;
  import trig_ctrl_pkg::*;
  logic        mclk, conv_start, conv_done, ext_trig_b;
  logic [2:0]  lit;
  logic        store_write, buffer_clear, mux_lock;
  logic        trigger_overrun_error, menu_advance;
  logic        rst_b = 0, reg_wr = 0, reg_rd = 0, remote = 0, key_any = 0;
  logic        rom_ok = 1, ram_ok = 1, slow = 0;
  logic [5:0]  kick = '0;
  logic [3:0]  reg_addr = '0;
  logic [1:0]  mux_sel;
  logic [7:0]  digit_all_on;
  logic [31:0] reg_wdata = '0, reg_rdata, v;
  int          mismatches = 0, samples_checked = 0;
  int          nconv, nstore, tfirst, tgap, n;

  trig_ctrl #(.TICK_DIV(4), .DISP_MS(1016), .MEM_MS(5)) i_trig_ctrl (
    .mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_trig_b, .src_operate(kick[1]), .bus_exec(kick[2]),
    .bus_get(kick[3]), .bus_talk(kick[4]), .key_trigger(kick[5]),
    .key_any, .remote, .conv_start, .conv_done, .store_write,
    .buffer_clear, .digit_all_on, .rom_ok, .ram_ok, .mux_lock, .mux_sel,
    .trigger_overrun_error, .menu_advance);
  trig_ctrl_partner i_trig_ctrl_partner (.mclk, .fire(kick[0]), .slow,
    .conv_start, .conv_done, .ext_trig_b);

  // 200 MHz clock
  initial
  begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end

  // ==========================================================
  // Access tasks
  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task win(input int x, input int lo, input int hi);
    check(32'(x >= lo && x <= hi), 32'h1);
  endtask : win
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    check(v & m, e);
  endtask : rdc
  task fire(input int k);
    @(posedge mclk);
    kick[k] <= 1'b1;
    @(posedge mclk);
    kick[k] <= 1'b0;
  endtask : fire
  // Counts readings and store writes, first offset and first gap
  task watch(input int cyc);
    nconv = 0;
    nstore = 0;
    tfirst = -1;
    tgap = -1;
    for (int i = 0; i < cyc; i++)
    begin
      @(posedge mclk);
      #1 nstore += store_write;
      if (conv_start === 1'b1)
      begin
        if (nconv == 1) tgap = i - tfirst;
        if (nconv == 0) tfirst = i;
        nconv++;
      end
    end
  endtask : watch
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    rdc(ADDR_MODE, 32'h3, 32'h0);
    rdc(ADDR_INTERVAL, 32'hfffff, 32'haf);
    rdc(ADDR_DELAY, 32'hfffff, 32'h0);
    rdc(ADDR_SOURCE, 32'h7, 32'h0);
    // Out-of-range settings are refused
    wr(ADDR_INTERVAL, 32'h9);
    wr(ADDR_INTERVAL, 32'hf4240);
    wr(ADDR_DELAY, 32'hf4240);
    rdc(ADDR_INTERVAL, 32'hfffff, 32'haf);
    rdc(ADDR_DELAY, 32'hfffff, 32'h0);
    wr(ADDR_INTERVAL, 32'hf423f);
    rdc(ADDR_INTERVAL, 32'hfffff, 32'hf423f);
    for (int s = 0; s < 6; s++)
    begin
      wr(ADDR_SOURCE, 32'(s));
      rdc(ADDR_SOURCE, 32'h7, s < 5 ? 32'(s) : 32'h4);
    end
    // Multiple series: delay only before the first reading
    wr(ADDR_SOURCE, 32'h0);
    wr(ADDR_DELAY, 32'ha);
    wr(ADDR_INTERVAL, 32'h3c);
    fire(0);
    watch(600);
    win(tfirst, 38, 52);
    win(tgap, 236, 244);
    wr(ADDR_INTERVAL, 32'h14);
    fire(0);
    watch(600);
    win(tgap, 196, 204);
    wr(ADDR_MODE, 32'h2);
    fire(0);
    watch(300);
    win(tgap, 76, 84);
    win(nstore, 3, 4);
    // One-shot: interval locked, full delay, retrigger overruns
    wr(ADDR_MODE, 32'h1);
    wr(ADDR_INTERVAL, 32'h64);
    rdc(ADDR_INTERVAL, 32'hfffff, 32'h14);
    fire(5);
    fire(5);
    watch(300);
    check(nconv, 1);
    win(tfirst, 32, 50);
    rdc(ADDR_STATUS, 32'h1, 32'h1);
    check(trigger_overrun_error, 32'h1);
    wr(ADDR_ERRCLR, 32'h1);
    rdc(ADDR_STATUS, 32'h1, 32'h0);
    check(trigger_overrun_error, 32'h0);
    @(posedge mclk);
    remote <= 1'b1;
    fire(5);
    watch(100);
    check(nconv, 0);
    @(posedge mclk);
    remote <= 1'b0;
    wr(ADDR_DELAY, 32'h0);
    for (int s = 1; s < 5; s++)
    begin
      wr(ADDR_SOURCE, 32'(s));
      fire(s);
      watch(40);
      check(nconv, 1);
    end
    fire(0);
    watch(40);
    check(nconv, 0);
    fire(5);
    watch(40);
    check(nconv, 1);
    // Retrigger while the converter is still busy
    @(posedge mclk);
    slow <= 1'b1;
    fire(5);
    fire(5);
    rdc(ADDR_STATUS, 32'h1, 32'h1);
    @(posedge mclk);
    slow <= 1'b0;
    // Defaults: factory, save, recall, ok
    wr(ADDR_DEFAULTS, 32'h3);
    rdc(ADDR_MODE, 32'h1, 32'h0);
    wr(ADDR_INTERVAL, 32'h21);
    wr(ADDR_DEFAULTS, 32'h1);
    wr(ADDR_INTERVAL, 32'h2c);
    wr(ADDR_DEFAULTS, 32'h2);
    rdc(ADDR_INTERVAL, 32'hfffff, 32'h21);
    wr(ADDR_DEFAULTS, 32'h3);
    wr(ADDR_DEFAULTS, 32'h2);
    rdc(ADDR_INTERVAL, 32'hfffff, 32'haf);
    wr(ADDR_DEFAULTS, 32'h0);
    // Self-test twice: program memory fault, then data memory fault
    for (int r = 0; r < 2; r++)
    begin
      @(posedge mclk);
      rom_ok <= r == 1;
      ram_ok <= r == 0;
      lit = 3'h0;
      wr(ADDR_SELFTEST, 32'h1);
      // A failed test stays in the test state until a key is pressed
      for (n = 0; n < 20000; n++)
      begin
        rd(ADDR_STATUS);
        if (digit_all_on === 8'hff) lit[0] = 1'b1;
        if (digit_all_on === 8'h01) lit[1] = 1'b1;
        if (digit_all_on === 8'h80) lit[2] = 1'b1;
        if (v[ST_TESTRUN_BIT] === 1'b0 || v[3:2] != 2'h0) break;
      end
      if (n == 20000)
      begin
        $display("mismatch t=%0t got=%h exp=%h", $time, v, 32'h0);
        mismatches++;
        test_done;
      end
      check(lit, 32'h7);
      check(v & 32'hc, r ? 32'h8 : 32'h4);
      @(posedge mclk);
      key_any <= 1'b1;
      @(posedge mclk);
      key_any <= 1'b0;
      rdc(ADDR_STATUS, 32'h1c, 32'h0);
    end
    // Debug lock; selector code 3 is ignored
    wr(ADDR_DEBUG, 32'h5);
    wr(ADDR_DEBUG, 32'h7);
    #1 check({mux_lock, mux_sel}, 32'h6);
    test_done;
  end
endmodule : trig_ctrl_bench
